// ---- hw/sgrc_cause_bit.sv ----
// One sticky reset cause flag
`timescale 1ns/1ps
module sgrc_cause_bit
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic set,
   input  wire logic clr,
   output logic      q
);
   typedef struct packed {logic flag;} sgrc_cbit_t;
   sgrc_cbit_t s_r;
   sgrc_cbit_t s_nxt;

   // ==========================================================
   // Flag
   always_comb
   begin
      s_nxt = s_r;
      // Set beats clear so an event in the clearing cycle survives
      s_nxt.flag = set | (s_r.flag & ~clr);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign q = s_r.flag;

   set_wins_a: assert property (@(posedge clk) disable iff (rst) set |=> q)
      else $error("cause flag lost its set");
   clr_done_a: assert property (@(posedge clk) disable iff (rst) clr && !set |=> !q)
      else $error("cause flag not cleared");
endmodule : sgrc_cause_bit

// ---- hw/sgrc_div_if.sv ----
// Link between the controller and its PWM clock divider
`timescale 1ns/1ps
interface sgrc_div_if;
   logic [2:0] sel;
   logic       srst;
   logic       tick;
   logic [2:0] active;
   modport ctl (output sel, output srst, input tick, input active);
   modport div (input sel, input srst, output tick, output active);
endinterface : sgrc_div_if

// ---- hw/sgrc_pkg.sv ----
// Shared constants and types of the sleep gating and reset cause controller
package sgrc_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [11:0] OFS_SLEEP_EN  = 12'h000;
   localparam logic [11:0] OFS_GATE_CTL  = 12'h004;
   localparam logic [11:0] OFS_PWM_DIV   = 12'h008;
   localparam logic [11:0] OFS_RESET_CTL = 12'h00c;
   localparam logic [11:0] OFS_CAUSE     = 12'h010;
   localparam logic [11:0] OFS_SRAM_SIZE = 12'h014;
   localparam logic [11:0] OFS_STATUS    = 12'h018;

   // ==========================================================
   // Reset cause bit positions
   localparam int CAUSE_W                      = 5;
   localparam int cause_software_reset         = 0;
   localparam int cause_watchdog_reset         = 1;
   localparam int cause_brownout_reset         = 2;
   localparam int cause_poweron_reset          = 3;
   localparam int cause_external_pin_reset     = 4;

   // ==========================================================
   // PWM divider codes, ratio is two to the power of the code
   localparam logic [2:0] pwm_clk_div_by_one       = 3'h0;
   localparam logic [2:0] pwm_clk_div_by_sixtyfour = 3'h6;
   localparam logic [5:0] PWM_CNT_FULL             = 6'h3f;

   // ==========================================================
   // Values after reset
   localparam logic [31:0] SLEEP_EN_RST = 32'h0000_0000;
   localparam logic        GATE_RST     = 1'b0;
   localparam logic [2:0]  PWM_DIV_RST  = pwm_clk_div_by_one;

   // ==========================================================
   // Timing
   localparam int         CLK_FREQ_MHZ  = 40;
   localparam int         SRST_PULSE_NS = 100;
   localparam logic [7:0] SRST_CYC      = 8'((SRST_PULSE_NS * CLK_FREQ_MHZ + 999) / 1000);

   typedef enum logic {SGRC_RUN, SGRC_SLEEP} sgrc_pmode_t;
endpackage : sgrc_pkg

// ---- hw/sgrc_pwm_div.sv ----
// PWM clock divider giving one tick per divided period
`timescale 1ns/1ps
module sgrc_pwm_div
(
   input  wire logic clk,
   input  wire logic rst,
   sgrc_div_if.div   bus
);
   typedef struct packed
   {
      logic [5:0] cnt;
      logic [2:0] act;
      logic       tick;
   } sgrc_div_t;
   sgrc_div_t  s_r;
   sgrc_div_t  s_nxt;
   logic [5:0] lim;

   // ==========================================================
   // Counter
   assign lim = sgrc_pkg::PWM_CNT_FULL >> (3'h6 - s_r.act);

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (bus.srst)
      begin
         s_nxt.cnt = 6'h00;
         s_nxt.act = sgrc_pkg::PWM_DIV_RST;
      end
      else if (s_r.cnt == lim)
      begin
         // New ratio only at a period boundary, so no short period
         s_nxt.cnt  = 6'h00;
         s_nxt.tick = 1'b1;
         s_nxt.act  = bus.sel;
      end
      else
         s_nxt.cnt = s_r.cnt + 6'h01;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_r     <= '0;
         s_r.act <= sgrc_pkg::PWM_DIV_RST;
      end
      else
         s_r <= s_nxt;
   end

   assign bus.tick   = s_r.tick;
   assign bus.active = s_r.act;

   div_apply_a: assert property (@(posedge clk) disable iff (rst)
      s_r.cnt == lim && !bus.srst |=> bus.tick && bus.active == $past(bus.sel))
      else $error("divider ratio not applied at the boundary");
   div_gap_a: assert property (@(posedge clk) disable iff (rst)
      bus.tick && s_r.act != 3'h0 |=> !bus.tick)
      else $error("divided period too short");
endmodule : sgrc_pwm_div

// ---- hw/sgrc_top.sv ----
// Sleep clock gating, PWM clock divider, software reset and reset cause flags
// Notes on behaviour
// - Sleep-enabled peripherals keep clock, can wake core
// - Gating off: sleep enables kept, no effect
// - Gating on: only sleep-enabled peripherals clocked in sleep
// - Core halted in sleep until wake event
// - PWM clock divides system clock by 1..64
// - Divider read returns one legal selection
// - Software reset resets core, peripherals, registers
// - Cause register kept, software flag set
// - Five independent cause flags, may combine
// - Flag sticks until cleared or external reset
// - Masked clear; later reset sets again
// - SRAM size readable in bytes
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module sgrc_top
#(
   parameter int          PERIPH_N   = 16,
   parameter logic [31:0] SRAM_BYTES = 32'h0000_8000
)
(
   input  wire logic                CLK_SYS,
   input  wire logic                RESET,
   input  wire logic                PSEL,
   input  wire logic                PENABLE,
   input  wire logic                PWRITE,
   input  wire logic [11:0]         PADDR,
   input  wire logic [31:0]         PWDATA,
   output logic      [31:0]         PRDATA,
   output logic                     PREADY,
   output logic                     PSLVERR,
   input  wire logic                SLEEP_REQ,
   input  wire logic [PERIPH_N-1:0] WAKE_EVT,
   output logic                     CORE_HALT,
   output logic      [PERIPH_N-1:0] PERIPH_CLK_EN,
   output logic                     PWM_TICK,
   output logic                     DEV_RESET,
   input  wire logic                RST_WDOG_IN,
   input  wire logic                RST_BOR_IN,
   input  wire logic                RST_POR_IN,
   input  wire logic                RST_EXT_IN
);
   typedef struct packed
   {
      logic [PERIPH_N-1:0]  sleep_en;
      logic                 gate;
      logic [2:0]           pwm_sel;
      sgrc_pkg::sgrc_pmode_t mode;
      logic [7:0]           srst_cnt;
      logic [3:0]           sync1;
      logic [3:0]           sync2;
      logic [3:0]           sync3;
      logic [31:0]          rdata;
      logic                 slverr;
   } sgrc_state_t;

   sgrc_state_t                    s_r;
   sgrc_state_t                    s_nxt;
   logic                           setup;
   logic                           access;
   logic                           wr;
   logic                           hit;
   logic [31:0]                    rd_val;
   logic [PERIPH_N-1:0]            clk_en;
   logic [3:0]                     rise;
   logic [sgrc_pkg::CAUSE_W-1:0]   cause_set;
   logic [sgrc_pkg::CAUSE_W-1:0]   cause_clr;
   logic [sgrc_pkg::CAUSE_W-1:0]   cause_q;
   logic                           srst_start;
   sgrc_div_if                     div_bus ();

   // ==========================================================
   // Bus phases
   assign setup      = PSEL & ~PENABLE;
   assign access     = PSEL & PENABLE;
   assign wr         = access & PWRITE;
   assign srst_start = wr && PADDR == sgrc_pkg::OFS_RESET_CTL && PWDATA[0] &&
                       s_r.srst_cnt == 8'h00;

   // ==========================================================
   // Clock gating
   always_comb
   begin
      if (s_r.mode == sgrc_pkg::SGRC_RUN || !s_r.gate)
         clk_en = '1;
      else
         clk_en = s_r.sleep_en;
   end

   // ==========================================================
   // Reset causes
   assign rise = s_r.sync2 & ~s_r.sync3;

   always_comb
   begin
      cause_set = {rise, srst_start};
      cause_clr = '0;
      if (wr && PADDR == sgrc_pkg::OFS_CAUSE)
         cause_clr = PWDATA[sgrc_pkg::CAUSE_W-1:0];
      // External reset wipes every other cause not set in the same cycle
      if (rise[3])
         cause_clr = '1;
   end

   for (genvar i = 0; i < sgrc_pkg::CAUSE_W; i++)
   begin : g_cause
      sgrc_cause_bit u_bit
      (
         .clk (CLK_SYS),
         .rst (RESET),
         .set (cause_set[i]),
         .clr (cause_clr[i]),
         .q   (cause_q[i])
      );
   end

   // ==========================================================
   // Read decode
   always_comb
   begin
      hit    = 1'b1;
      rd_val = 32'h0000_0000;
      case (PADDR)
         sgrc_pkg::OFS_SLEEP_EN:  rd_val = 32'(s_r.sleep_en);
         sgrc_pkg::OFS_GATE_CTL:  rd_val = {31'h0, s_r.gate};
         sgrc_pkg::OFS_PWM_DIV:   rd_val = {29'h0, s_r.pwm_sel};
         sgrc_pkg::OFS_RESET_CTL: rd_val = 32'h0000_0000;
         sgrc_pkg::OFS_CAUSE:     rd_val = {27'h0, cause_q};
         sgrc_pkg::OFS_SRAM_SIZE: rd_val = SRAM_BYTES;
         sgrc_pkg::OFS_STATUS:    rd_val = {31'h0, s_r.mode == sgrc_pkg::SGRC_SLEEP};
         default:                 hit    = 1'b0;
      endcase
   end

   // ==========================================================
   // Next state
   always_comb
   begin
      s_nxt       = s_r;
      s_nxt.sync1 = {RST_EXT_IN, RST_POR_IN, RST_BOR_IN, RST_WDOG_IN};
      s_nxt.sync2 = s_r.sync1;
      s_nxt.sync3 = s_r.sync2;
      if (setup)
      begin
         s_nxt.rdata  = rd_val;
         s_nxt.slverr = ~hit;
      end
      case (s_r.mode)
         sgrc_pkg::SGRC_RUN:
            if (SLEEP_REQ)
               s_nxt.mode = sgrc_pkg::SGRC_SLEEP;
         sgrc_pkg::SGRC_SLEEP:
            if (|(WAKE_EVT & clk_en))
               s_nxt.mode = sgrc_pkg::SGRC_RUN;
         default:
            s_nxt.mode = sgrc_pkg::SGRC_RUN;
      endcase
      if (wr)
      begin
         case (PADDR)
            sgrc_pkg::OFS_SLEEP_EN:
               s_nxt.sleep_en = PWDATA[PERIPH_N-1:0];
            sgrc_pkg::OFS_GATE_CTL:
               s_nxt.gate = PWDATA[0];
            sgrc_pkg::OFS_PWM_DIV:
               // Codes above the last ratio are dropped, keeping the read legal
               if (PWDATA[2:0] <= sgrc_pkg::pwm_clk_div_by_sixtyfour)
                  s_nxt.pwm_sel = PWDATA[2:0];
            sgrc_pkg::OFS_RESET_CTL:
               if (srst_start)
                  s_nxt.srst_cnt = sgrc_pkg::SRST_CYC;
            default:
               s_nxt.gate = s_r.gate;
         endcase
      end
      // Cause flags live outside this struct, so they ride through
      if (s_r.srst_cnt != 8'h00)
      begin
         s_nxt.srst_cnt = s_r.srst_cnt - 8'h01;
         s_nxt.sleep_en = sgrc_pkg::SLEEP_EN_RST[PERIPH_N-1:0];
         s_nxt.gate     = sgrc_pkg::GATE_RST;
         s_nxt.pwm_sel  = sgrc_pkg::PWM_DIV_RST;
         s_nxt.mode     = sgrc_pkg::SGRC_RUN;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RESET)
   begin
      if (RESET)
      begin
         s_r         <= '0;
         s_r.gate    <= sgrc_pkg::GATE_RST;
         s_r.pwm_sel <= sgrc_pkg::PWM_DIV_RST;
         s_r.mode    <= sgrc_pkg::SGRC_RUN;
      end
      else
         s_r <= s_nxt;
   end

   // ==========================================================
   // PWM divider
   assign div_bus.sel  = s_r.pwm_sel;
   assign div_bus.srst = DEV_RESET;

   sgrc_pwm_div u_div
   (
      .clk (CLK_SYS),
      .rst (RESET),
      .bus (div_bus)
   );

   // ==========================================================
   // Outputs
   assign PRDATA        = s_r.rdata;
   assign PREADY        = access;
   assign PSLVERR       = access & s_r.slverr;
   assign CORE_HALT     = s_r.mode == sgrc_pkg::SGRC_SLEEP;
   assign PERIPH_CLK_EN = clk_en;
   assign PWM_TICK      = div_bus.tick;
   assign DEV_RESET     = s_r.srst_cnt != 8'h00;

   // ==========================================================
   // Checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);

   sequence srst_pulse;
      DEV_RESET [*4] ##1 !DEV_RESET;
   endsequence
   sequence srst_req;
      srst_start && !DEV_RESET;
   endsequence

   sleep_entry_a: assert property (!CORE_HALT && SLEEP_REQ && !DEV_RESET |=> CORE_HALT)
      else $error("sleep request did not halt the core");
   sleep_hold_a: assert property (CORE_HALT && !(|(WAKE_EVT & PERIPH_CLK_EN)) && !DEV_RESET
      |=> CORE_HALT)
      else $error("core left sleep without a wake event");
   wake_run_a: assert property (CORE_HALT && |(WAKE_EVT & PERIPH_CLK_EN) |=> !CORE_HALT)
      else $error("wake event ignored");
   gate_off_a: assert property (!s_r.gate || !CORE_HALT |-> &PERIPH_CLK_EN)
      else $error("peripheral clock stopped without gating");
   gate_on_a: assert property (CORE_HALT && s_r.gate |-> PERIPH_CLK_EN == s_r.sleep_en)
      else $error("sleep gating does not follow sleep enables");
   pwm_legal_a: assert property (s_r.pwm_sel <= sgrc_pkg::pwm_clk_div_by_sixtyfour)
      else $error("illegal divider selection stored");
   srst_len_a: assert property (srst_req |=> srst_pulse)
      else $error("software reset pulse has wrong length");
   srst_dflt_a: assert property (DEV_RESET |=> !s_r.gate && s_r.pwm_sel == 3'h0 &&
      !CORE_HALT && s_r.sleep_en == '0)
      else $error("registers not at defaults after software reset");
   srst_cause_a: assert property (srst_req |=> cause_q[0])
      else $error("software reset flag not set");
   cause_keep_a: assert property (DEV_RESET && cause_clr == '0 |=>
      cause_q == ($past(cause_q) | $past(cause_set)))
      else $error("cause register disturbed by software reset");
   cause_set_a: assert property (|cause_set |=>
      (cause_q & $past(cause_set)) == $past(cause_set))
      else $error("cause flag not recorded");
   ext_wipe_a: assert property (rise[3] |=> cause_q == (5'h10 | $past(cause_set)))
      else $error("external reset did not wipe other causes");
   sram_rd_a: assert property (setup && PADDR == sgrc_pkg::OFS_SRAM_SIZE |=>
      PRDATA == SRAM_BYTES)
      else $error("wrong SRAM size read");

   // ==========================================================
   // Register checks
   // Writes are exempt while DEV_RESET forces defaults, so those are lost on purpose
   ena_store_a: assert property (wr && PADDR == sgrc_pkg::OFS_SLEEP_EN && !DEV_RESET
      |=> s_r.sleep_en == $past(PWDATA[PERIPH_N-1:0]))
      else $error("sleep enables not stored");
   div_store_a: assert property (wr && PADDR == sgrc_pkg::OFS_PWM_DIV && !DEV_RESET &&
      PWDATA[2:0] <= sgrc_pkg::pwm_clk_div_by_sixtyfour |=> s_r.pwm_sel == $past(PWDATA[2:0]))
      else $error("legal divider code not stored");
   div_drop_a: assert property (wr && PADDR == sgrc_pkg::OFS_PWM_DIV && !DEV_RESET &&
      PWDATA[2:0] > sgrc_pkg::pwm_clk_div_by_sixtyfour |=> $stable(s_r.pwm_sel))
      else $error("illegal divider code not dropped");
   // Reads land one cycle after setup, in the access phase
   div_read_a: assert property (setup && PADDR == sgrc_pkg::OFS_PWM_DIV |=>
      PRDATA == {29'h0, $past(s_r.pwm_sel)})
      else $error("divider read does not match selection");
   cause_read_a: assert property (setup && PADDR == sgrc_pkg::OFS_CAUSE |=>
      PRDATA == {27'h0, $past(cause_q)})
      else $error("cause read does not match flags");
   cause_clr_a: assert property (wr && PADDR == sgrc_pkg::OFS_CAUSE |=>
      (cause_q & $past(PWDATA[sgrc_pkg::CAUSE_W-1:0]) & ~$past(cause_set)) ==
      5'h00)
      else $error("masked cause flags not cleared");
   status_read_a: assert property (setup && PADDR == sgrc_pkg::OFS_STATUS |=>
      PRDATA == {31'h0, $past(CORE_HALT)})
      else $error("status read does not match sleep state");
   // Unmapped addresses answer with an error and zero data
   unmap_err_a: assert property (setup && !hit ##1 access |->
      PSLVERR && PRDATA == 32'h0000_0000)
      else $error("unmapped access without error");
   map_ok_a: assert property (setup && hit ##1 access |->
      !PSLVERR)
      else $error("mapped access flagged as error");
endmodule : sgrc_top

// ---- test/sgrc_core_model.sv ----
// Behavioural core and peripherals on the far side of the controller
`timescale 1ns/1ps
module sgrc_core_model
#(
   parameter int PERIPH_N = 16
)
(
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                sleep_cmd,
   input  wire logic [PERIPH_N-1:0] wake_cmd,
   input  wire logic [3:0]          rst_cmd,
   input  wire logic                core_halt,
   input  wire logic [PERIPH_N-1:0] clk_en,
   input  wire logic                dev_reset,
   output logic                     sleep_req,
   output logic      [PERIPH_N-1:0] wake_evt,
   output logic      [3:0]          rst_src
);
   // ==========================================================
   // Core and peripheral behaviour
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sleep_req <= 1'b0;
         wake_evt  <= '0;
         rst_src   <= 4'h0;
      end
      else
      begin
         // Core held in reset cannot ask for sleep
         sleep_req <= sleep_cmd & ~core_halt & ~dev_reset;
         // Unclocked peripheral has no logic running to wake
         wake_evt  <= wake_cmd & clk_en;
         rst_src   <= rst_cmd;
      end
   end
endmodule : sgrc_core_model

// ---- test/tb_sgrc_top.sv ----
// Self-checking bench of the sleep gating and reset cause controller
`timescale 1ns/1ps
module tb_sgrc_top;
   // ==========================================================
   // Signals
   typedef struct packed {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] e;
      logic err;} sgrc_row_t;
   logic        clk_sys = 1'b0;
   logic        reset   = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0;
   logic        sleep_cmd = 1'b0;
   logic [15:0] wake_cmd  = 16'h0;
   logic [3:0]  rst_cmd   = 4'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        sleep_req;
   logic [15:0] wake_evt;
   logic        core_halt;
   logic [15:0] clk_en;
   logic        pwm_tick;
   logic        dev_reset;
   logic [3:0]  rst_src;
   logic [31:0] rd;
   logic        er;
   int          bad_count  = 0;
   int          num_checks = 0;
   int          n;
   sgrc_row_t   rows [11] = '{
      '{1'b0, sgrc_pkg::OFS_SLEEP_EN, 32'h0, 32'h0, 1'b0},
      '{1'b0, sgrc_pkg::OFS_GATE_CTL, 32'h0, 32'h0, 1'b0},
      '{1'b0, sgrc_pkg::OFS_PWM_DIV, 32'h0, 32'h0, 1'b0},
      '{1'b0, sgrc_pkg::OFS_CAUSE, 32'h0, 32'h0, 1'b0},
      '{1'b0, sgrc_pkg::OFS_SRAM_SIZE, 32'h0, 32'h8000, 1'b0},
      '{1'b0, sgrc_pkg::OFS_STATUS, 32'h0, 32'h0, 1'b0},
      '{1'b1, sgrc_pkg::OFS_SLEEP_EN, 32'ha5c3, 32'ha5c3, 1'b0},
      '{1'b1, sgrc_pkg::OFS_PWM_DIV, 32'h3, 32'h3, 1'b0},
      '{1'b1, sgrc_pkg::OFS_PWM_DIV, 32'h7, 32'h3, 1'b0},
      '{1'b1, sgrc_pkg::OFS_SRAM_SIZE, 32'h1234, 32'h8000, 1'b0},
      '{1'b1, 12'h01c, 32'h5, 32'h0, 1'b1}};

   always #12.5 clk_sys = ~clk_sys;

   sgrc_top u_dut (.CLK_SYS(clk_sys), .RESET(reset), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .SLEEP_REQ(sleep_req), .WAKE_EVT(wake_evt), .CORE_HALT(core_halt),
      .PERIPH_CLK_EN(clk_en), .PWM_TICK(pwm_tick), .DEV_RESET(dev_reset),
      .RST_WDOG_IN(rst_src[0]), .RST_BOR_IN(rst_src[1]), .RST_POR_IN(rst_src[2]),
      .RST_EXT_IN(rst_src[3]));

   sgrc_core_model u_core (.clk(clk_sys), .rst(reset), .sleep_cmd(sleep_cmd),
      .wake_cmd(wake_cmd), .rst_cmd(rst_cmd), .core_halt(core_halt), .clk_en(clk_en),
      .dev_reset(dev_reset), .sleep_req(sleep_req), .wake_evt(wake_evt), .rst_src(rst_src));

   // ==========================================================
   // Tasks
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask : chk

   task automatic hang(input string nm);
      $display("[FAIL] %s expected done seen timeout", nm);
      bad_count++;
      close_out();
   endtask : hang

   // Request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      for (k = 0; k < 20; k++)
      begin
         @(posedge clk_sys);
         if (pready === 1'b1)
            break;
      end
      if (k == 20)
         hang("pready");
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask : rd_chk

   task automatic wait_halt(input logic v);
      int k;
      for (k = 0; k < 10 && core_halt !== v; k++)
         @(posedge clk_sys);
      if (k == 10)
         hang("core halt");
   endtask : wait_halt

   task automatic wait_tick;
      int k;
      for (k = 0; k < 200; k++)
      begin
         @(posedge clk_sys);
         if (pwm_tick === 1'b1)
            break;
      end
      if (k == 200)
         hang("pwm tick");
   endtask : wait_tick

   task automatic pulse(input int i);
      @(posedge clk_sys);
      rst_cmd[i] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rst_cmd[i] <= 1'b0;
      repeat (6) @(posedge clk_sys);
   endtask : pulse

   // ==========================================================
   // Sequence
   initial
   begin
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      foreach (rows[i])
      begin
         if (rows[i].wr)
            apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 32'h0);
         chk("row read", rows[i].e, rd);
         chk("row error", {31'h0, rows[i].err}, {31'h0, er});
      end
      $display("register rows done");
      for (int c = 0; c < 7; c++)
      begin
         apb(1'b1, sgrc_pkg::OFS_PWM_DIV, 32'(c));
         wait_tick();
         wait_tick();
         n = 0;
         do
         begin
            @(posedge clk_sys);
            n++;
         end
         while (pwm_tick !== 1'b1 && n < 200);
         chk("pwm period", 32'h1 << c, 32'(n));
      end
      $display("pwm divider done");
      apb(1'b1, sgrc_pkg::OFS_SLEEP_EN, 32'h0005);
      for (int g = 0; g < 2; g++)
      begin
         apb(1'b1, sgrc_pkg::OFS_GATE_CTL, 32'(g));
         @(posedge clk_sys);
         sleep_cmd <= 1'b1;
         wait_halt(1'b1);
         sleep_cmd <= 1'b0;
         chk("sleep clocks", g ? 32'h5 : 32'hffff, {16'h0, clk_en});
         rd_chk(sgrc_pkg::OFS_STATUS, 32'h1, "status");
         wake_cmd <= 16'h0002;
         repeat (8) @(posedge clk_sys);
         chk("halt kept", {31'h0, g[0]}, {31'h0, core_halt});
         wake_cmd <= 16'h0004;
         wait_halt(1'b0);
         wake_cmd <= 16'h0000;
         repeat (4) @(posedge clk_sys);
         rd_chk(sgrc_pkg::OFS_SLEEP_EN, 32'h5, "enables kept");
      end
      $display("sleep gating done");
      for (int i = 0; i < 3; i++)
         pulse(i);
      rd_chk(sgrc_pkg::OFS_CAUSE, 32'h0e, "cause combined");
      apb(1'b1, sgrc_pkg::OFS_CAUSE, 32'h02);
      rd_chk(sgrc_pkg::OFS_CAUSE, 32'h0c, "masked clear");
      pulse(0);
      rd_chk(sgrc_pkg::OFS_CAUSE, 32'h0e, "cause again");
      apb(1'b1, sgrc_pkg::OFS_PWM_DIV, 32'h2);
      apb(1'b1, sgrc_pkg::OFS_RESET_CTL, 32'h1);
      for (n = 0; n < 5 && dev_reset !== 1'b1; n++)
         @(posedge clk_sys);
      for (n = 0; n < 20 && dev_reset === 1'b1; n++)
         @(posedge clk_sys);
      chk("reset length", 32'(sgrc_pkg::SRST_CYC), 32'(n));
      rd_chk(sgrc_pkg::OFS_CAUSE, 32'h0f, "cause kept");
      rd_chk(sgrc_pkg::OFS_SLEEP_EN, 32'h0, "enables reset");
      rd_chk(sgrc_pkg::OFS_PWM_DIV, 32'h0, "divider reset");
      pulse(3);
      rd_chk(sgrc_pkg::OFS_CAUSE, 32'h10, "external clears");
      apb(1'b1, sgrc_pkg::OFS_CAUSE, 32'h1f);
      rd_chk(sgrc_pkg::OFS_CAUSE, 32'h0, "all cleared");
      $display("reset causes done");
      pulse(1);
      @(posedge clk_sys);
      reset <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk("clocks in reset", 32'hffff, {16'h0, clk_en});
      reset <= 1'b0;
      rd_chk(sgrc_pkg::OFS_CAUSE, 32'h0, "cause after reset");
      $display("mid run reset done");
      close_out();
   end
endmodule : tb_sgrc_top
